// >>> core/device_status_and_checksum_regs.sv
// Summary of operation
// - Mode field bits 7-5, reset 100b.
// - Active, all channels off reports code 6.
// - Active, any channel on reports code 7.
// - Bit 4 follows PLL enabled state.
// - Bit 3 follows mic bias enabled state.
// - Bit 1 flags input-fault record shutdown.
// - Bit 0 flags bias-fault full record shutdown.
// - Bit 2 reserved, reads zero.
// - Writing checksum register loads written byte.
// - Any other register write updates checksum.
// - Record channels powered only while power-up set.
`timescale 1ns/100ps
`default_nettype none

module device_status_and_checksum_regs (
    // Clock and reset.
    input  wire logic                              i_ref_clk,
    input  wire logic                              i_nrst,
    // Register write port from the control-bus decoder.
    input  wire logic                              i_wr_en,
    input  wire logic [dev_status_pkg::PAGE_W-1:0] i_wr_page,
    input  wire logic [dev_status_pkg::ADDR_W-1:0] i_wr_addr,
    input  wire logic [dev_status_pkg::DATA_W-1:0] i_wr_data,
    // Register read port.
    input  wire logic                              i_rd_en,
    input  wire logic [dev_status_pkg::PAGE_W-1:0] i_rd_page,
    input  wire logic [dev_status_pkg::ADDR_W-1:0] i_rd_addr,
    output logic      [dev_status_pkg::DATA_W-1:0] o_rd_data,
    output logic                                   o_rd_hit,
    // Power-state signals from the power-up control logic.
    input  wire logic                              i_sleep,
    input  wire logic                              i_record_power_up,
    input  wire logic [dev_status_pkg::CH_N-1:0]   i_record_ch_enable,
    input  wire logic [dev_status_pkg::CH_N-1:0]   i_playback_ch_on,
    // Analog-side levels, asynchronous to the clock.
    input  wire logic                              i_pll_enabled,
    input  wire logic                              i_bias_enabled,
    input  wire logic                              i_input_fault_pd,
    input  wire logic                              i_bias_fault_pd,
    // Derived outputs.
    output logic      [dev_status_pkg::CH_N-1:0]   o_record_ch_on,
    output logic      [dev_status_pkg::DATA_W-1:0] o_checksum,
    output logic      [dev_status_pkg::DATA_W-1:0] o_status
);
    import dev_status_pkg::*;

    logic [CH_N-1:0]   record_on_reg;
    logic [CH_N-1:0]   record_on_next;
    logic [DATA_W-1:0] status_reg;
    logic [DATA_W-1:0] status_next;
    logic [DATA_W-1:0] rd_data_reg;
    logic [DATA_W-1:0] rd_data_next;
    logic              rd_hit_reg;
    logic              rd_hit_next;
    logic [2:0]        mode_next;
    logic [3:0]        analog_level;
    logic [DATA_W-1:0] checksum_value;

    // True when a page and address select the given register on page zero.
    function automatic logic reg_select(input logic [PAGE_W-1:0] page,
                                        input logic [ADDR_W-1:0] addr,
                                        input logic [ADDR_W-1:0] target);
        return (page == STATUS_PAGE) && (addr == target);
    endfunction : reg_select

    wire pll_level         = analog_level[3];
    wire bias_level        = analog_level[2];
    wire input_fault_level = analog_level[1];
    wire bias_fault_level  = analog_level[0];

    // Address decode for the write and read ports.
    wire wr_checksum_hit = i_wr_en && reg_select(i_wr_page, i_wr_addr, CHECKSUM_ADDR);
    wire wr_other_hit    = i_wr_en && !wr_checksum_hit;
    wire rd_status_hit   = i_rd_en && reg_select(i_rd_page, i_rd_addr, STATUS_ONE_ADDR);
    wire rd_checksum_hit = i_rd_en && reg_select(i_rd_page, i_rd_addr, CHECKSUM_ADDR);

    // Analog flags cross into the clock domain through a filtered chain.
    pin_level_filter #(
        .WIDTH       (4),
        .RESET_VALUE (4'h0)
    ) u_analog_sync (
        .i_ref_clk (i_ref_clk),
        .i_nrst    (i_nrst),
        .i_raw     ({i_pll_enabled, i_bias_enabled, i_input_fault_pd, i_bias_fault_pd}),
        .o_level   (analog_level)
    );

    // Checksum register: the written byte loads it, other writes fold in.
    write_checksum_unit u_checksum (
        .i_ref_clk (i_ref_clk),
        .i_nrst    (i_nrst),
        .i_load    (wr_checksum_hit),
        .i_fold    (wr_other_hit),
        .i_data    (i_wr_data),
        .o_value   (checksum_value)
    );

    // Record channels run only when enabled and the power-up bit is set.
    assign record_on_next = i_record_power_up ? i_record_ch_enable : '0;

    // Mode: sleep wins, otherwise active idle or active busy.
    assign mode_next = i_sleep ? MODE_SLEEP :
                       ((|record_on_reg) || (|i_playback_ch_on)) ? MODE_ACTIVE_BUSY
                                                                 : MODE_ACTIVE_IDLE;

    // Assemble the status byte; the reserved bit is tied low.
    always_comb begin
        status_next                  = '0;
        status_next[MODE_MSB:MODE_LSB] = mode_next;
        status_next[PLL_BIT]         = pll_level;
        status_next[BIAS_BIT]        = bias_level;
        status_next[RESERVED_BIT]    = 1'b0;
        status_next[INPUT_FAULT_BIT] = input_fault_level;
        status_next[BIAS_FAULT_BIT]  = bias_fault_level;
    end

    // Read selection; an unmapped address answers zero with no hit.
    assign rd_data_next = rd_status_hit   ? status_reg :
                          rd_checksum_hit ? checksum_value : '0;
    assign rd_hit_next  = rd_status_hit || rd_checksum_hit;

    // Status and channel state registers.
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            status_reg    <= STATUS_ONE_RESET;
            record_on_reg <= '0;
        end else begin
            status_reg    <= status_next;
            record_on_reg <= record_on_next;
        end
    end

    // Read answer registers, one cycle after the request.
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            rd_data_reg <= '0;
            rd_hit_reg  <= 1'b0;
        end else begin
            rd_data_reg <= rd_data_next;
            rd_hit_reg  <= rd_hit_next;
        end
    end

    // Output drive.
    assign o_rd_data      = rd_data_reg;
    assign o_rd_hit       = rd_hit_reg;
    assign o_record_ch_on = record_on_reg;
    assign o_checksum     = checksum_value;
    assign o_status       = status_reg;

    // Checks on the status byte, the checksum and the channel gating.
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_nrst);

    wire [2:0] mode_now = status_reg[MODE_MSB:MODE_LSB];
    wire any_channel_on = (|record_on_reg) || (|i_playback_ch_on);

    // Sleep shows as code 4 on the next edge.
    a_mode_sleep_code: assert property (
        i_sleep |=> (mode_now == MODE_SLEEP))
        else $error("Mode field is not sleep after sleep request.");

    // Reserved mode codes never appear.
    a_mode_no_reserved: assert property (
        (mode_now == MODE_SLEEP) || (mode_now == MODE_ACTIVE_IDLE) ||
        (mode_now == MODE_ACTIVE_BUSY))
        else $error("Mode field holds a reserved code.");

    // Active with every channel off reports idle.
    a_mode_active_idle: assert property (
        (!i_sleep && !any_channel_on) |=> (mode_now == MODE_ACTIVE_IDLE))
        else $error("Active idle mode not reported.");

    // Active with a channel on reports busy.
    a_mode_active_busy: assert property (
        (!i_sleep && any_channel_on) |=> (mode_now == MODE_ACTIVE_BUSY))
        else $error("Active busy mode not reported.");

    // PLL and bias bits follow the synchronised levels one edge later.
    a_pll_bias_track: assert property (
        ##1 (status_reg[PLL_BIT] == $past(pll_level)) &&
            (status_reg[BIAS_BIT] == $past(bias_level)))
        else $error("PLL or bias status bit does not follow its level.");

    // A raw PLL rise held steady reaches the status bit within five edges.
    a_pll_pin_latency: assert property (
        ($rose(i_pll_enabled) ##1 i_pll_enabled [*4]) |=> status_reg[PLL_BIT])
        else $error("PLL status bit slow to follow its pin.");

    // Fault shutdown bits follow their levels one edge later.
    a_fault_flags_track: assert property (
        ##1 (status_reg[INPUT_FAULT_BIT] == $past(input_fault_level)) &&
            (status_reg[BIAS_FAULT_BIT] == $past(bias_fault_level)))
        else $error("Fault shutdown bit does not follow its level.");

    // The reserved bit is always low, and so is its read-back.
    a_reserved_reads_zero: assert property (
        !status_reg[RESERVED_BIT] &&
        !(o_rd_hit && $past(rd_status_hit) && o_rd_data[RESERVED_BIT]))
        else $error("Reserved status bit reads as one.");

    // A checksum write loads the written byte.
    a_checksum_load: assert property (
        wr_checksum_hit |=> (checksum_value == $past(i_wr_data)))
        else $error("Checksum write did not load the written value.");

    // Other writes fold the byte by CRC-8; no write leaves it alone.
    a_checksum_fold: assert property (
        wr_other_hit |=> (checksum_value == crc8_step($past(checksum_value), $past(i_wr_data))))
        else $error("Checksum not folded on a register write.");

    a_checksum_hold: assert property (
        !i_wr_en |=> $stable(checksum_value))
        else $error("Checksum changed with no write.");

    // Record channels are off one edge after the power-up bit drops.
    a_record_gate_off: assert property (
        !i_record_power_up |=> (record_on_reg == '0))
        else $error("Record channel on without power-up bit.");

    // Reset loads the status and checksum reset values.
    a_status_reset_value: assert property (
        disable iff (1'b0)
        !i_nrst |=> (status_reg == STATUS_ONE_RESET))
        else $error("Status byte not at its reset value after reset.");

    a_checksum_reset_value: assert property (
        disable iff (1'b0)
        !i_nrst |=> (checksum_value == CHECKSUM_RESET))
        else $error("Checksum not at its reset value after reset.");

    // A status read returns the status byte one edge later.
    a_read_status_data: assert property (
        rd_status_hit |=> (o_rd_hit && (o_rd_data == $past(status_reg))))
        else $error("Status read returned the wrong byte.");

    // A checksum read returns the checksum one edge later.
    a_read_checksum_data: assert property (
        rd_checksum_hit |=> (o_rd_hit && (o_rd_data == $past(checksum_value))))
        else $error("Checksum read returned the wrong byte.");

    // With the power-up bit set, enabled record channels come on.
    a_record_gate_on: assert property (
        i_record_power_up |=> (record_on_reg == $past(i_record_ch_enable)))
        else $error("Enabled record channel not powered with power-up bit set.");

    // Playback alone, or a record channel alone, makes the device busy.
    a_busy_from_playback: assert property (
        (!i_sleep && (|i_playback_ch_on)) |=> (mode_now == MODE_ACTIVE_BUSY))
        else $error("Busy mode not reported with playback on.");

    a_busy_from_record: assert property (
        (!i_sleep && (|record_on_reg)) |=> (mode_now == MODE_ACTIVE_BUSY))
        else $error("Busy mode not reported with a record channel on.");

    // Idle is only reported when the device was awake with all channels off.
    a_idle_all_off: assert property (
        (mode_now == MODE_ACTIVE_IDLE) |-> (!$past(i_sleep) && !$past(any_channel_on)))
        else $error("Idle mode reported while asleep or with a channel on.");

    // A PLL pin held low clears its status bit within five edges.
    a_pll_pin_fall: assert property (
        ($fell(i_pll_enabled) ##1 (!i_pll_enabled) [*4]) |=> !status_reg[PLL_BIT])
        else $error("PLL status bit slow to clear.");

    // A bias pin held high sets its status bit within five edges.
    a_bias_pin_rise: assert property (
        ($rose(i_bias_enabled) ##1 i_bias_enabled [*4]) |=> status_reg[BIAS_BIT])
        else $error("Bias status bit slow to set.");

    // A bias pin held low clears its status bit within five edges.
    a_bias_pin_fall: assert property (
        ($fell(i_bias_enabled) ##1 (!i_bias_enabled) [*4]) |=> !status_reg[BIAS_BIT])
        else $error("Bias status bit slow to clear.");

    // An input fault shutdown held high sets its flag within five edges.
    a_input_fault_rise: assert property (
        ($rose(i_input_fault_pd) ##1 i_input_fault_pd [*4]) |=> status_reg[INPUT_FAULT_BIT])
        else $error("Input fault flag slow to set.");

    // An input fault shutdown that ends clears its flag within five edges.
    a_input_fault_fall: assert property (
        ($fell(i_input_fault_pd) ##1 (!i_input_fault_pd) [*4]) |=>
        !status_reg[INPUT_FAULT_BIT])
        else $error("Input fault flag slow to clear.");

    // A bias fault shutdown held high sets its flag within five edges.
    a_bias_fault_rise: assert property (
        ($rose(i_bias_fault_pd) ##1 i_bias_fault_pd [*4]) |=> status_reg[BIAS_FAULT_BIT])
        else $error("Bias fault flag slow to set.");

    // A bias fault shutdown that ends clears its flag within five edges.
    a_bias_fault_fall: assert property (
        ($fell(i_bias_fault_pd) ##1 (!i_bias_fault_pd) [*4]) |=> !status_reg[BIAS_FAULT_BIT])
        else $error("Bias fault flag slow to clear.");

    // Main scenarios.
    c_sleep_to_busy:   cover property (i_sleep ##1 !i_sleep && any_channel_on ##1
                                       mode_now == MODE_ACTIVE_BUSY);
    c_checksum_load:   cover property (wr_checksum_hit ##1 wr_other_hit);
    c_status_read:     cover property (rd_status_hit ##1 o_rd_hit);
    c_fault_shutdown:  cover property ($rose(status_reg[BIAS_FAULT_BIT]));

endmodule : device_status_and_checksum_regs

`default_nettype wire

// >>> include/dev_status_pkg.sv
package dev_status_pkg;

    // Control-bus geometry.
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int PAGE_W = 8;
    localparam int CH_N   = 4;

    // Register map: both registers live on page zero.
    localparam logic [PAGE_W-1:0] STATUS_PAGE      = 8'h00;
    localparam logic [ADDR_W-1:0] STATUS_ONE_ADDR  = 8'h7A;
    localparam logic [ADDR_W-1:0] CHECKSUM_ADDR    = 8'h7E;

    // Reset values.
    localparam logic [DATA_W-1:0] STATUS_ONE_RESET = 8'h80;
    localparam logic [DATA_W-1:0] CHECKSUM_RESET   = 8'h00;

    // Field positions inside the status register.
    localparam int MODE_MSB         = 7;
    localparam int MODE_LSB         = 5;
    localparam int PLL_BIT          = 4;
    localparam int BIAS_BIT         = 3;
    localparam int RESERVED_BIT     = 2;
    localparam int INPUT_FAULT_BIT  = 1;
    localparam int BIAS_FAULT_BIT   = 0;

    // Operating mode codes.
    localparam logic [2:0] MODE_SLEEP       = 3'h4;
    localparam logic [2:0] MODE_ACTIVE_IDLE = 3'h6;
    localparam logic [2:0] MODE_ACTIVE_BUSY = 3'h7;

    // Pin synchroniser depth and checksum polynomial (x^8 + x^2 + x + 1).
    localparam int                SYNC_STAGES  = 3;
    localparam logic [DATA_W-1:0] CHECKSUM_POLY = 8'h07;

    // One CRC-8 step over a whole written byte, msb first.
    function automatic logic [DATA_W-1:0] crc8_step(input logic [DATA_W-1:0] crc,
                                                   input logic [DATA_W-1:0] data);
        logic [DATA_W-1:0] acc;
        acc = crc ^ data;
        for (int i = 0; i < DATA_W; i++) begin
            acc = acc[DATA_W-1] ? ((acc << 1) ^ CHECKSUM_POLY) : (acc << 1);
        end
        return acc;
    endfunction : crc8_step

endpackage : dev_status_pkg

// >>> core/pin_level_filter.sv
`timescale 1ns/100ps
`default_nettype none

module pin_level_filter #(
    parameter int WIDTH  = 4,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    // Clock and reset.
    input  wire logic             i_ref_clk,
    input  wire logic             i_nrst,
    // Levels from another domain and their filtered copy.
    input  wire logic [WIDTH-1:0] i_raw,
    output logic      [WIDTH-1:0] o_level
);
    import dev_status_pkg::*;

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync2_reg;
    logic [WIDTH-1:0] sync3_reg;
    logic [WIDTH-1:0] level_reg;
    logic [WIDTH-1:0] level_next;
    wire  [WIDTH-1:0] agree_w;

    // A bit changes only when the second and third stages agree.
    assign agree_w    = ~(sync2_reg ^ sync3_reg);
    assign level_next = (agree_w & sync2_reg) | (~agree_w & level_reg);
    assign o_level    = level_reg;

    // Three-stage chain; the first stage feeds only the second.
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            meta_reg  <= RESET_VALUE;
            sync2_reg <= RESET_VALUE;
            sync3_reg <= RESET_VALUE;
            level_reg <= RESET_VALUE;
        end else begin
            meta_reg  <= i_raw;
            sync2_reg <= meta_reg;
            sync3_reg <= sync2_reg;
            level_reg <= level_next;
        end
    end

endmodule : pin_level_filter

`default_nettype wire

// >>> core/write_checksum_unit.sv
`timescale 1ns/100ps
`default_nettype none

module write_checksum_unit (
    // Clock and reset.
    input  wire logic                              i_ref_clk,
    input  wire logic                              i_nrst,
    // Load a new value or fold a written byte in.
    input  wire logic                              i_load,
    input  wire logic                              i_fold,
    input  wire logic [dev_status_pkg::DATA_W-1:0] i_data,
    // Current checksum.
    output logic      [dev_status_pkg::DATA_W-1:0] o_value
);
    import dev_status_pkg::*;

    logic [DATA_W-1:0] sum_reg;
    logic [DATA_W-1:0] sum_next;

    // A load takes the written byte; any other write folds it in by CRC-8.
    assign sum_next = i_load ? i_data :
                      i_fold ? crc8_step(sum_reg, i_data) : sum_reg;
    assign o_value  = sum_reg;

    // Checksum storage.
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            sum_reg <= CHECKSUM_RESET;
        end else begin
            sum_reg <= sum_next;
        end
    end

endmodule : write_checksum_unit

`default_nettype wire

// >>> verification/power_ctrl_model.sv
`timescale 1ns/100ps
`default_nettype none

module power_ctrl_model (
    // Requested states from the bench: sleep, power-up, record enables, playback on.
    input  wire logic [2*dev_status_pkg::CH_N+1:0] i_req,
    input  wire logic [3:0]                        i_req_async,
    // Levels seen by the status block.
    output wire logic                              o_sleep,
    output wire logic                              o_record_power_up,
    output wire logic [dev_status_pkg::CH_N-1:0]   o_record_ch_enable,
    output wire logic [dev_status_pkg::CH_N-1:0]   o_playback_ch_on,
    output wire logic [3:0]                        o_analog
);
    import dev_status_pkg::*;

    // Sequencer levels settle a few ns after the request, well clear of the edge.
    assign #3 {o_sleep, o_record_power_up, o_record_ch_enable, o_playback_ch_on} = i_req;
    // Analog levels move off the clock grid, so the block must filter them.
    assign #7 o_analog = i_req_async;
endmodule : power_ctrl_model
`default_nettype wire

// >>> verification/tb.sv
`timescale 1ns/100ps
`default_nettype none

module tb;
    import dev_status_pkg::*;
    logic              i_ref_clk;
    logic              i_nrst;
    logic              wr_en;
    logic              rd_en;
    logic [7:0]        wr_page;
    logic [7:0]        wr_addr;
    logic [7:0]        wr_data;
    logic [7:0]        rd_page;
    logic [7:0]        rd_addr;
    logic [2*CH_N+1:0] req;
    logic [3:0]        req_async;
    wire logic         sleep;
    wire logic         pup;
    wire logic [3:0]   rec_en;
    wire logic [3:0]   play_on;
    wire logic [3:0]   analog;
    logic [7:0]        rd_data;
    logic [7:0]        checksum;
    logic [7:0]        status;
    logic [7:0]        crc;
    logic              rd_hit;
    logic [3:0]        rec_on;
    logic [3:0]        flag_tbl [6];
    int                n_errors;
    int                cmp_count;

    // Bench-side CRC-8, polynomial 0x07, msb first.
    function automatic logic [7:0] ref_crc(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] r;
        r = c ^ d;
        for (int i = 0; i < 8; i++) begin
            r = r[7] ? ((r << 1) ^ 8'h07) : (r << 1);
        end
        return r;
    endfunction : ref_crc

    // Compares one byte and counts it.
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic step(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask : step

    // One written byte; the strobe stays up so writes may follow back to back.
    task automatic wr(input logic [7:0] p, input logic [7:0] a, input logic [7:0] d);
        wr_en = 1'b1;
        wr_page = p;
        wr_addr = a;
        wr_data = d;
        crc = (p == STATUS_PAGE && a == CHECKSUM_ADDR) ? d : ref_crc(crc, d);
        step(1);
        chk("checksum", crc, checksum);
    endtask : wr

    // One read; the strobe stays up so reads may follow back to back.
    task automatic rd(input logic [7:0] p, input logic [7:0] a, input logic [7:0] exp,
                      input logic hit);
        rd_en = 1'b1;
        rd_page = p;
        rd_addr = a;
        step(1);
        chk("read_data", exp, rd_data);
        chk("read_hit", {7'h00, hit}, {7'h00, rd_hit});
    endtask : rd

    // Prints the verdict and ends the run.
    task automatic results;
        if (n_errors == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : results

    // Sets the far-side request and waits for it to reach the status byte.
    task automatic set_req(input logic [2*CH_N+1:0] r);
        req = r;
        step(3);
    endtask : set_req

    power_ctrl_model power_ctrl_model_inst (
        .i_req              (req),
        .i_req_async        (req_async),
        .o_sleep            (sleep),
        .o_record_power_up  (pup),
        .o_record_ch_enable (rec_en),
        .o_playback_ch_on   (play_on),
        .o_analog           (analog)
    );

    device_status_and_checksum_regs device_status_and_checksum_regs_inst (
        .i_ref_clk          (i_ref_clk),
        .i_nrst             (i_nrst),
        .i_wr_en            (wr_en),
        .i_wr_page          (wr_page),
        .i_wr_addr          (wr_addr),
        .i_wr_data          (wr_data),
        .i_rd_en            (rd_en),
        .i_rd_page          (rd_page),
        .i_rd_addr          (rd_addr),
        .o_rd_data          (rd_data),
        .o_rd_hit           (rd_hit),
        .i_sleep            (sleep),
        .i_record_power_up  (pup),
        .i_record_ch_enable (rec_en),
        .i_playback_ch_on   (play_on),
        .i_pll_enabled      (analog[3]),
        .i_bias_enabled     (analog[2]),
        .i_input_fault_pd   (analog[1]),
        .i_bias_fault_pd    (analog[0]),
        .o_record_ch_on     (rec_on),
        .o_checksum         (checksum),
        .o_status           (status)
    );

    // Free-running 50 MHz clock.
    initial begin
        i_ref_clk = 1'b0;
        forever #10 i_ref_clk = ~i_ref_clk;
    end

    // Cuts a hang short well after the tests should have ended.
    initial begin
        #20000;
        n_errors++;
        results();
    end

    // Main test sequence.
    initial begin
        n_errors = 0;
        cmp_count = 0;
        crc = 8'h00;
        {i_nrst, wr_en, rd_en} = 3'h0;
        {wr_page, wr_addr, wr_data, rd_page, rd_addr} = 40'h00_0000_0000;
        req = 10'h200;
        req_async = 4'h0;
        flag_tbl = '{4'h8, 4'h4, 4'h2, 4'h1, 4'hF, 4'h0};
        step(3);
        i_nrst = 1'b1;
        chk("status_reset", STATUS_ONE_RESET, status);
        chk("checksum_reset", CHECKSUM_RESET, checksum);
        rd(STATUS_PAGE, STATUS_ONE_ADDR, 8'h80, 1'b1);
        rd_en = 1'b0;
        set_req(10'h000);
        chk("mode_idle", {MODE_ACTIVE_IDLE, 5'h00}, status);
        set_req({2'h0, 4'hF, 4'h0});
        chk("rec_unpowered", 8'h00, {4'h0, rec_on});
        chk("mode_idle_en", {MODE_ACTIVE_IDLE, 5'h00}, status);
        set_req({2'h1, 4'h5, 4'h0});
        chk("rec_powered", 8'h05, {4'h0, rec_on});
        chk("mode_busy_rec", {MODE_ACTIVE_BUSY, 5'h00}, status);
        set_req({2'h0, 4'h5, 4'h0});
        chk("rec_dropped", 8'h00, {4'h0, rec_on});
        set_req({2'h0, 4'h0, 4'h8});
        chk("mode_busy_play", {MODE_ACTIVE_BUSY, 5'h00}, status);
        set_req({2'h2, 4'h0, 4'h8});
        chk("mode_sleep", {MODE_SLEEP, 5'h00}, status);
        // Walk each analog flag alone, then all together, then none.
        foreach (flag_tbl[i]) begin
            req_async = flag_tbl[i];
            step(6);
            chk("flags", {MODE_SLEEP, flag_tbl[i][3:2], 1'b0, flag_tbl[i][1:0]}, status);
        end
        // Checksum load and fold, back to back across pages.
        wr(STATUS_PAGE, CHECKSUM_ADDR, 8'h55);
        wr(STATUS_PAGE, 8'h10, 8'h01);
        wr(8'h01, CHECKSUM_ADDR, 8'hA7);
        wr(STATUS_PAGE, STATUS_ONE_ADDR, STATUS_ONE_RESET);
        wr(8'hFF, 8'h00, 8'hFF);
        wr(STATUS_PAGE, CHECKSUM_ADDR, 8'h00);
        wr(8'h02, 8'h33, 8'h80);
        wr_en = 1'b0;
        chk("status_kept", {MODE_SLEEP, 5'h00}, status);
        rd(STATUS_PAGE, CHECKSUM_ADDR, crc, 1'b1);
        rd(STATUS_PAGE, 8'h7B, 8'h00, 1'b0);
        rd(8'h01, STATUS_ONE_ADDR, 8'h00, 1'b0);
        rd_en = 1'b0;
        // Reset again in mid-run with the device awake and busy.
        set_req({2'h1, 4'hF, 4'hF});
        i_nrst = 1'b0;
        crc = 8'h00;
        step(1);
        chk("status_rst2", STATUS_ONE_RESET, status);
        chk("checksum_rst2", CHECKSUM_RESET, checksum);
        i_nrst = 1'b1;
        wr(8'h05, 8'h20, 8'hC3);
        wr_en = 1'b0;
        step(2);
        results();
    end
endmodule : tb
`default_nettype wire
